// ===== core/rivm_consts.vh
// Vector offsets, field positions, reset values and timing counts of the reset and interrupt vector map
`ifndef RIVM_CONSTS_VH
`define RIVM_CONSTS_VH
`define RIVM_ADDR_W 12
`define RIVM_NUM_SRC 16
`define RIVM_RESET_VEC 12'h000
`define RIVM_TABLE_BASE 12'h001
`define RIVM_VEC_EXT0 5'h01
`define RIVM_VEC_EXT1 5'h02
`define RIVM_VEC_T16_CAP 5'h03
`define RIVM_VEC_T16_MA 5'h04
`define RIVM_VEC_T16_MB 5'h05
`define RIVM_VEC_T16_OVF 5'h06
`define RIVM_VEC_T8_OVF 5'h07
`define RIVM_VEC_SERIAL 5'h08
`define RIVM_VEC_URX 5'h09
`define RIVM_VEC_UTXE 5'h0A
`define RIVM_VEC_UTX 5'h0B
`define RIVM_VEC_COMP 5'h0C
`define RIVM_VEC_EXT2 5'h0D
`define RIVM_VEC_T8_MATCH 5'h0E
`define RIVM_VEC_NVRDY 5'h0F
`define RIVM_VEC_PSRDY 5'h10
`define RIVM_FUSE_UNPROG 1'b1
`define RIVM_FUSE_PROG 1'b0
`define RIVM_CTL_SEL_BIT 1
`define RIVM_CTL_CE_BIT 0
`define RIVM_CHG_WINDOW_CYC 3'h4
`define RIVM_BOOT_START_DEF 12'hC00
`endif

// ===== core/rivm_vec_rom.v
// Registered lookup of vector offset per request line
`default_nettype none
module rivm_vec_rom (
  input wire clk,
  input wire rst_n,
  input wire [3:0] index,
  output reg [4:0] offset
);
  `include "rivm_consts.vh"
  reg [4:0] lookup;
  always @* begin
    case (index)
      4'h0: lookup = `RIVM_VEC_EXT0;
      4'h1: lookup = `RIVM_VEC_EXT1;
      4'h2: lookup = `RIVM_VEC_T16_CAP;
      4'h3: lookup = `RIVM_VEC_T16_MA;
      4'h4: lookup = `RIVM_VEC_T16_MB;
      4'h5: lookup = `RIVM_VEC_T16_OVF;
      4'h6: lookup = `RIVM_VEC_T8_OVF;
      4'h7: lookup = `RIVM_VEC_SERIAL;
      4'h8: lookup = `RIVM_VEC_URX;
      4'h9: lookup = `RIVM_VEC_UTXE;
      4'hA: lookup = `RIVM_VEC_UTX;
      4'hB: lookup = `RIVM_VEC_COMP;
      4'hC: lookup = `RIVM_VEC_EXT2;
      4'hD: lookup = `RIVM_VEC_T8_MATCH;
      4'hE: lookup = `RIVM_VEC_NVRDY;
      4'hF: lookup = `RIVM_VEC_PSRDY;
      default: lookup = `RIVM_VEC_EXT0;
    endcase
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      offset <= 5'h00;
    end else begin
      offset <= lookup;
    end
  end
endmodule
`default_nettype wire

// ===== core/rivm_vector_map.v
// Reset and interrupt vector map with table relocation and timed change sequence
`default_nettype none
module rivm_vector_map (
  input wire clk,
  input wire rst_n,
  input wire boot_reset_select_fuse,
  input wire [11:0] bootStartAddr,
  input wire ctlWrite,
  input wire [7:0] ctlWriteData,
  input wire instrRetire,
  input wire globalIrqEnable,
  input wire [15:0] irqRequest,
  input wire irqTaken,
  output reg [11:0] resetVector,
  output reg vector_table_select,
  output reg vector_change_enable,
  output wire [7:0] general_irq_control,
  output reg irqValid,
  output reg [11:0] irqVector,
  output reg [3:0] irqIndex,
  output wire dispatchBlocked
);
  `include "rivm_consts.vh"
  // ==========================================
  // Priority pick
  function [4:0] rivm_pick;
    input [15:0] req;
    integer i;
    begin
      rivm_pick = 5'h10;
      for (i = 15; i >= 0; i = i - 1) begin
        if (req[i]) begin
          rivm_pick = i[4:0];
        end
      end
    end
  endfunction
  // ==========================================
  // Region base: zero or the boot section start
  function [11:0] rivm_region_base;
    input useBoot;
    input [11:0] bootAddr;
    begin
      if (useBoot) begin
        rivm_region_base = bootAddr;
      end else begin
        rivm_region_base = `RIVM_RESET_VEC;
      end
    end
  endfunction
  reg [2:0] ceCount;
  reg holdPending;
  reg fuseSeen;
  reg fuseMeta;
  reg fuseSync;
  reg [3:0] pickIndex;
  reg pickValid;
  wire [11:0] tableBase;
  wire [4:0] romOffset;
  wire [4:0] picked;
  wire selWrite;
  wire ceSet;
  assign general_irq_control = {6'h00, vector_table_select, vector_change_enable};
  assign selWrite = ctlWrite && vector_change_enable && !ctlWriteData[`RIVM_CTL_CE_BIT];
  assign ceSet = ctlWrite && ctlWriteData[`RIVM_CTL_CE_BIT];
  assign picked = rivm_pick(irqRequest);
  // Block covers enable window and one instruction past the select write
  assign dispatchBlocked = vector_change_enable || holdPending;
  // ==========================================
  // Fuse level is not timed to clk, so it passes two stages
  // No reset here: the stages settle while reset is held
  always @(posedge clk) begin
    fuseMeta <= boot_reset_select_fuse;
    fuseSync <= fuseMeta;
  end
  // ==========================================
  // Reset vector from fuse, caught after release
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resetVector <= `RIVM_RESET_VEC;
      fuseSeen <= 1'b0;
    end else if (!fuseSeen) begin
      fuseSeen <= 1'b1;
      if (fuseSync == `RIVM_FUSE_UNPROG) begin
        resetVector <= `RIVM_RESET_VEC;
      end else begin
        resetVector <= bootStartAddr;
      end
    end
  end
  // ==========================================
  // Table select, written only inside an open change window
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vector_table_select <= 1'b0;
    end else if (selWrite) begin
      vector_table_select <= ctlWriteData[`RIVM_CTL_SEL_BIT];
    end
  end
  // ==========================================
  // Change window: open four cycles, closed early by a select write
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vector_change_enable <= 1'b0;
      ceCount <= 3'h0;
    end else if (selWrite) begin
      vector_change_enable <= 1'b0;
      ceCount <= 3'h0;
    end else if (ceSet) begin
      vector_change_enable <= 1'b1;
      ceCount <= `RIVM_CHG_WINDOW_CYC - 3'h1;
    end else if (vector_change_enable) begin
      if (ceCount == 3'h0) begin
        vector_change_enable <= 1'b0;
      end else begin
        ceCount <= ceCount - 3'h1;
      end
    end
  end
  // ==========================================
  // Dispatch hold past the select write; a new write wins over a retire
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      holdPending <= 1'b0;
    end else if (selWrite) begin
      holdPending <= 1'b1;
    end else if (holdPending && instrRetire) begin
      holdPending <= 1'b0;
    end
  end
  // ==========================================
  // Vector address formation
  assign tableBase = rivm_region_base(vector_table_select, bootStartAddr);
  rivm_vec_rom vecRom (
    .clk(clk),
    .rst_n(rst_n),
    .index(picked[3:0]),
    .offset(romOffset)
  );
  // Pick registered alongside ROM so index and offset stay aligned
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pickIndex <= 4'h0;
      pickValid <= 1'b0;
    end else begin
      pickIndex <= picked[3:0];
      pickValid <= !picked[4];
    end
  end
  // Global enable untouched here; blocking only gates dispatch
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqValid <= 1'b0;
      irqVector <= `RIVM_RESET_VEC;
      irqIndex <= 4'h0;
    end else begin
      // Window opening withdraws an offer in its own cycle already
      if (irqTaken || ceSet || dispatchBlocked || !globalIrqEnable || !pickValid) begin
        irqValid <= 1'b0;
      end else begin
        irqValid <= 1'b1;
        irqVector <= tableBase + {7'h00, romOffset};
        irqIndex <= pickIndex;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/rivm_vector_map_props.sv
// Port checks for the vector map
`default_nettype none
module rivm_vector_map_props (
  input wire clk,
  input wire rst_n,
  input wire boot_reset_select_fuse,
  input wire [11:0] bootStartAddr,
  input wire ctlWrite,
  input wire [11:0] resetVector,
  input wire vector_table_select,
  input wire vector_change_enable,
  input wire irqValid,
  input wire [11:0] irqVector,
  input wire [3:0] irqIndex,
  input wire dispatchBlocked
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_ce_window: assert property ($rose(vector_change_enable) |-> ##[1:4] !vector_change_enable)
    else $error("ce held");
  a_ce_cause: assert property ($rose(vector_change_enable) |-> $past(ctlWrite))
    else $error("ce cause");
  a_sel_guard: assert property ($changed(vector_table_select) |-> $past(vector_change_enable) && $past(ctlWrite))
    else $error("sel guard");
  a_ce_blocks: assert property (vector_change_enable |-> !irqValid)
    else $error("ce block");
  a_block_cause: assert property ($rose(dispatchBlocked) |-> vector_change_enable)
    else $error("block cause");
  a_no_offer: assert property (dispatchBlocked && !irqValid |=> !irqValid)
    else $error("offer blocked");
  a_reset_addr: assert property ($past(rst_n) |->
    resetVector == (boot_reset_select_fuse ? 12'h000 : bootStartAddr)) else $error("reset addr");
  a_vector_sum: assert property (irqValid |-> irqVector ==
    (vector_table_select ? bootStartAddr : 12'h000) + {8'h00, irqIndex} + 12'h001) else $error("vector sum");
  c_move: cover property ($rose(vector_table_select));
  c_lapse: cover property ($fell(vector_change_enable) && !$past(ctlWrite));
  c_last: cover property (irqValid && irqIndex == 4'hF);
endmodule
bind rivm_vector_map rivm_vector_map_props u_rivm_vector_map_props (.*);
`default_nettype wire

// ===== tb/rivm_core_model.sv
// Core model: retires instructions, accepts offers after lag cycles
`default_nettype none
module rivm_core_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic irqValid,
  input wire logic [1:0] lag,
  output logic irqTaken,
  output logic instrRetire
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] waitCnt;
  // Two-cycle instructions leave a gap before the retire ending the hold
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waitCnt <= 2'h0;
      irqTaken <= 1'b0;
      instrRetire <= 1'b0;
    end else begin
      instrRetire <= ~instrRetire;
      irqTaken <= irqValid && !irqTaken && waitCnt == lag;
      waitCnt <= (irqValid && !irqTaken) ? waitCnt + 2'h1 : 2'h0;
    end
  end
endmodule
`default_nettype wire

// ===== tb/test_rivm_vector_map.sv
// Bench for the vector map
`default_nettype none
module test_rivm_vector_map;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, boot_reset_select_fuse = 1, ctlWrite = 0, globalIrqEnable = 1;
  logic [7:0] ctlWriteData = 0;
  logic [15:0] irqRequest = 0;
  logic [11:0] bootStartAddr = 12'h0C00;
  logic [1:0] lag = 0;
  wire logic [11:0] resetVector, irqVector;
  wire logic [3:0] irqIndex;
  wire logic [7:0] general_irq_control;
  wire logic vector_table_select, vector_change_enable, irqValid, dispatchBlocked, irqTaken, instrRetire;
  int fails = 0, comparisons = 0;
  rivm_vector_map u_rivm_vector_map (.*);
  rivm_core_model u_rivm_core_model (.*);
  initial forever #50 clk = ~clk;
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wv;
    for (int k = 0; k < 9 && irqValid !== 1'b1; k++) step(1);
  endtask
  task automatic wr(input logic [7:0] d);
    ctlWrite = 1;
    ctlWriteData = d;
    step(1);
    ctlWrite = 0;
  endtask
  task automatic rst(input logic f);
    rst_n = 0;
    boot_reset_select_fuse = f;
    step(10);
    rst_n = 1;
    step(3);
    chk({4'h0, resetVector}, {4'h0, f ? 12'h000 : bootStartAddr});
  endtask
  task automatic vec(input logic [11:0] b);
    for (int i = 0; i < 16; i++) begin
      irqRequest = 16'hFFFF << i;
      wv();
      chk({irqIndex, irqVector}, {i[3:0], b + i[11:0] + 12'h001});
      irqRequest = 16'h0000;
      step(4);
    end
  endtask
  task automatic masked;
    globalIrqEnable = 0;
    irqRequest = 16'h0010;
    step(4);
    chk({15'h0, irqValid}, 16'h0000);
    globalIrqEnable = 1;
    wv();
    chk({irqIndex, irqVector}, {4'h4, 12'h005});
    irqRequest = 16'h0000;
    step(4);
  endtask
  task automatic move(input logic s);
    irqRequest = 16'h0001;
    step(2);
    wr(8'h01);
    chk({13'h0, vector_change_enable, dispatchBlocked, irqValid}, 16'h0006);
    step(1);
    wr({6'h00, s, 1'b0});
    chk({13'h0, vector_table_select, vector_change_enable, dispatchBlocked}, {13'h0, s, 2'b01});
    chk({8'h00, general_irq_control}, {14'h0, s, 1'b0});
    wv();
    chk({4'h0, irqVector}, {4'h0, s ? bootStartAddr + 12'h001 : 12'h001});
    irqRequest = 16'h0000;
    step(4);
  endtask
  task automatic lapse(input logic s);
    wr(8'h01);
    step(5);
    wr({6'h00, ~s, 1'b0});
    chk({14'h0, vector_table_select, vector_change_enable}, {14'h0, s, 1'b0});
  endtask
  task automatic report_and_stop;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    rst(1'b1);
    vec(12'h000);
    masked();
    move(1'b1);
    lag = 2'h3;
    vec(bootStartAddr);
    lapse(1'b1);
    move(1'b0);
    rst(1'b0);
    move(1'b1);
    chk({4'h0, resetVector}, {4'h0, bootStartAddr});
    report_and_stop();
  end
  initial begin
    #200us;
    fails++;
    report_and_stop();
  end
endmodule
`default_nettype wire
